//--- dv/oscc_ext_clk_model.sv
// Purpose: Logic-level external clock source for the oscillator input pin.
// Assumes: Half period keeps the rate inside the high-power band.
// Notes: Holds low while disabled, so no stale edges reach the pin.
module oscc_ext_clk_model
#(
  parameter int HALF_NS = 50
)
(
  input wire logic en,
  output logic clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // 10 MHz logic-level clock, gated by en
  initial
  begin
    clk_o = 1'h0;
    forever
    begin
      #HALF_NS;
      clk_o = en ? ~clk_o : 1'h0;
    end
  end
endmodule

//--- dv/oscc_monitor.sv
// Purpose: Port checker for the oscillator clock source control block.
// Assumes: Strap inputs hold steady from reset release onward.
// Notes: Boot checks wait four edges, past the strap latch point.
module oscc_monitor
  import oscc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] clock_source_cfg,
  input wire logic clock_out_enable_n,
  input wire logic power_up_timer_en,
  input wire logic watchdog_timer_en,
  input wire logic sleep_mode,
  input wire logic frc_request,
  input wire oscc_osc_en_t osc_en,
  input wire logic clock_input_pin_is_io,
  input wire logic clock_output_pin_oe,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Pin function follows the active-low strap
  a_clock_output_pin_drive: assert property (!clock_out_enable_n |-> clock_output_pin_oe)
    else $error("clock out pin not driven while enabled");
  a_clock_output_pin_io: assert property (clock_out_enable_n |-> !clock_output_pin_oe)
    else $error("clock out pin driven while set to io");
  // Peripheral oscillator must follow frc_request, sleep or not
  a_frc_auto: assert property (frc_request |-> osc_en.frc_en)
    else $error("peripheral oscillator off while requested");
  a_frc_sleep: assert property ((sleep_mode && frc_request) [*2] |-> osc_en.frc_en)
    else $error("peripheral oscillator stopped in sleep");
  a_lf_timers: assert property ((power_up_timer_en || watchdog_timer_en) |-> osc_en.lf_en)
    else $error("low oscillator off while a timer needs it");
  // Boot state is taken from the strap after release
  a_pin_free: assert property ($rose(aresetn) |->
    ##4 (clock_input_pin_is_io == (clock_source_cfg == OSCC_CFG_INT)))
    else $error("clock input pin function wrong after boot");
  a_hf_boot: assert property ($rose(aresetn) && clock_source_cfg == OSCC_CFG_INT |->
    ##4 osc_en.hf_en)
    else $error("high oscillator off after internal boot");
  a_ext_boot: assert property ($rose(aresetn) && clock_source_cfg != OSCC_CFG_INT |->
    ##4 !osc_en.hf_en)
    else $error("high oscillator on after external boot");

  c_write: cover property (s_axi_awvalid && s_axi_awready);
  c_frc_on: cover property ($rose(osc_en.frc_en));
  c_lf_on: cover property ($rose(osc_en.lf_en));
endmodule

bind oscc_top oscc_monitor oscc_monitor_inst (.aclk, .aresetn, .clock_source_cfg,
  .clock_out_enable_n, .power_up_timer_en, .watchdog_timer_en, .sleep_mode, .frc_request,
  .osc_en, .clock_input_pin_is_io, .clock_output_pin_oe, .s_axi_awvalid, .s_axi_awready);

//--- dv/tb_oscillator_clock_source_control.sv
// Purpose: Self-checking bench for the oscillator clock source control block.
// Assumes: Start-up counts shortened to 20 and 40 cycles.
// Notes: Registers are reached only through the AXI4-Lite tasks.
module tb_oscillator_clock_source_control
  import oscc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [1:0] clock_source_cfg = 2'h0;
  logic clock_out_enable_n = 1'h1;
  logic power_up_timer_en = 1'h0;
  logic watchdog_timer_en = 1'h0;
  logic sleep_mode = 1'h0;
  logic frc_request = 1'h0;
  logic ext_en = 1'h0;
  logic hf_osc_clk = 1'h0;
  logic lf_osc_clk = 1'h0;
  logic frc_osc_clk = 1'h0;
  logic startup_osc_clk = 1'h0;
  logic oscillator_input_pin, sys_clk, clock_input_pin_is_io;
  logic clock_output_pin_oe, clock_output_pin_o;
  oscc_pclk_t pclk_req = '0;
  oscc_osc_en_t osc_en;
  logic [6:0] pclk_out;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] d;
  int err_count = 0;
  int check_count = 0;
  int sys_n = 0;
  int pin_n = 0;

  // Clocks; oscillators run unrelated in phase to aclk
  initial
  begin
    forever #2 aclk = ~aclk;
  end
  initial forever #31.25 hf_osc_clk = ~hf_osc_clk;
  initial forever #16129 lf_osc_clk = ~lf_osc_clk;
  initial forever #833 frc_osc_clk = ~frc_osc_clk;
  initial forever #41 startup_osc_clk = ~startup_osc_clk;
  always @(posedge sys_clk) sys_n++;
  always @(posedge oscillator_input_pin) pin_n++;

  oscc_top #(.HF_START_CYC(20), .HF_STABLE_CYC(40)) oscc_top_inst (.aclk, .aresetn,
    .clock_source_cfg, .clock_out_enable_n, .power_up_timer_en, .watchdog_timer_en,
    .sleep_mode, .frc_request, .oscillator_input_pin, .hf_osc_clk, .lf_osc_clk,
    .frc_osc_clk, .startup_osc_clk, .pclk_req, .osc_en, .sys_clk, .clock_input_pin_is_io,
    .clock_output_pin_oe, .clock_output_pin_o, .pclk_out, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  oscc_ext_clk_model oscc_ext_clk_model_inst (.en(ext_en), .clk_o(oscillator_input_pin));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Strap is applied while reset is held
  task automatic rst(input logic [1:0] c);
    @(posedge aclk);
    clock_source_cfg <= c;
    aresetn <= 1'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (6) @(posedge aclk);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit pa;
    bit pw;
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    pa = 1'h1;
    pw = 1'h1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'h1)
        pa = 1'h0;
      if (s_axi_wready === 1'h1)
        pw = 1'h0;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    while ((pa || pw || s_axi_bvalid !== 1'h1) && n < 64);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 64)
      err_count++;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    bit pa;
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    pa = 1'h1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'h1)
        pa = 1'h0;
      s_axi_arvalid <= pa;
    end
    while ((pa || s_axi_rvalid !== 1'h1) && n < 64);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 64)
      err_count++;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
    input string nm);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk(nm, v & m, e);
  endtask

  // Hang guard, well past the expected run length
  initial
  begin
    #50000;
    err_count++;
    stop_test();
  end

  initial
  begin
    // Every strap code, each through a full reset
    for (int c = 0; c < 4; c++)
    begin
      rst(c[1:0]);
      rchk(OSCC_CTRL_OFS, 32'h7F, 32'h38, "ctrl after reset");
      rchk(OSCC_CFG_OFS, 32'h3, 32'(c), "strap readback");
      chk("hf boot", osc_en.hf_en, c == 0);
      chk("pin is io", clock_input_pin_is_io, c == 0);
    end
    $display("test strap codes done");
    // External high-power source drives the system clock
    ext_en <= 1'h1;
    repeat (40) @(posedge aclk);
    sys_n = 0;
    pin_n = 0;
    repeat (400) @(posedge aclk);
    chk("ext follow", pin_n > 10 && sys_n >= pin_n - 2 && sys_n <= pin_n + 2, 1);
    wr(OSCC_CTRL_OFS, 32'h7D, r);
    rchk(OSCC_CTRL_OFS, 32'h7F, 32'h79, "reserved select kept");
    chk("reserved acts as default", osc_en.hf_en, 0);
    wr(OSCC_CTRL_OFS, 32'h7A, r);
    chk("switch to internal", osc_en.hf_en, 1);
    wr(OSCC_CTRL_OFS, 32'h78, r);
    chk("switch back", osc_en.hf_en, 0);
    wr(OSCC_STAT_OFS, 32'h0, r);
    chk("status write refused", r, OSCC_RESP_SLVERR);
    rd(12'h010, d, r);
    chk("unmapped read", r, OSCC_RESP_SLVERR);
    $display("test external source done");
    // Pins, timers, sleep and peripheral requests
    @(posedge aclk);
    clock_out_enable_n <= 1'h0;
    power_up_timer_en <= 1'h1;
    sleep_mode <= 1'h1;
    frc_request <= 1'h1;
    repeat (3) @(posedge aclk);
    chk("lf for power-up timer", osc_en.lf_en, 1);
    chk("frc in sleep", osc_en.frc_en, 1);
    #0.1;
    chk("clock out pin", {clock_output_pin_oe, clock_output_pin_o}, {1'h1, sys_clk});
    rchk(OSCC_CFG_OFS, 32'hC, 32'h4, "clock out strap");
    power_up_timer_en <= 1'h0;
    watchdog_timer_en <= 1'h1;
    frc_request <= 1'h0;
    pclk_req.conv_sel <= 2'h1;
    repeat (3) @(posedge aclk);
    chk("lf for watchdog", osc_en.lf_en, 1);
    chk("frc on converter request", osc_en.frc_en, 1);
    watchdog_timer_en <= 1'h0;
    pclk_req.conv_sel <= 2'h0;
    clock_out_enable_n <= 1'h1;
    repeat (3) @(posedge aclk);
    chk("lf idle", osc_en.lf_en, 0);
    chk("frc idle", osc_en.frc_en, 0);
    $display("test pins and requests done");
    // Internal block: frequency codes and flag order
    rst(2'h0);
    for (int i = 0; i < 16; i++)
    begin
      wr(OSCC_CTRL_OFS, {25'h0, i[3:0], 1'h0, 2'h2}, r);
      chk("hf per code", osc_en.hf_en, i >= 2);
      chk("lf per code", osc_en.lf_en, i < 2);
    end
    wr(OSCC_CTRL_OFS, 32'h02, r);
    repeat (4) @(posedge aclk);
    rchk(OSCC_STAT_OFS, 32'h113, 32'h002, "lf only flags");
    wr(OSCC_CTRL_OFS, 32'h7A, r);
    rchk(OSCC_STAT_OFS, 32'h013, 32'h000, "hf starting");
    repeat (22) @(posedge aclk);
    rchk(OSCC_STAT_OFS, 32'h013, 32'h010, "hf ready not stable");
    repeat (25) @(posedge aclk);
    rchk(OSCC_STAT_OFS, 32'h013, 32'h011, "hf stable");
    // 16 MHz gives 25.6 edges in 1600 ns, code 1101 gives 6.4
    sys_n = 0;
    repeat (400) @(posedge aclk);
    chk("full rate", sys_n >= 24 && sys_n <= 27, 1);
    wr(OSCC_CTRL_OFS, 32'h6A, r);
    sys_n = 0;
    repeat (400) @(posedge aclk);
    chk("quarter rate", sys_n >= 5 && sys_n <= 8, 1);
    $display("test internal block done");
    // Peripheral clock choices, sampled clear of every source edge
    @(posedge aclk);
    pclk_req <= '{2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 3'h2};
    @(posedge aclk);
    #0.1;
    chk("alt clocks", pclk_out, {sys_clk, hf_osc_clk, lf_osc_clk, sys_clk, hf_osc_clk,
      hf_osc_clk, frc_osc_clk});
    @(posedge aclk);
    pclk_req <= '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 3'h3};
    @(posedge aclk);
    #0.1;
    chk("system clocks", pclk_out, {sys_clk, lf_osc_clk, {5{sys_clk}}});
    $display("test peripheral clocks done");
    stop_test();
  end
endmodule

//--- rtl/oscc_glitch_mux.sv
// Purpose: Glitch-free two-input clock multiplexer.
// Assumes: Both inputs already safe to toggle; select is synchronous to aclk.
// Notes: Each path drops its enable on its own low phase before the other rises.
module oscc_glitch_mux
  import oscc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_a,
  input wire logic clk_b,
  input wire logic sel_b,
  output logic clk_out,
  output logic sel_b_done
);
  logic a_en_ff;
  logic b_en_ff;

  // Enable hand-off: old path off, then new path on, never both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      a_en_ff <= 1'b1;
      b_en_ff <= 1'b0;
    end
    else
    begin
      if (sel_b && !clk_a)
        a_en_ff <= 1'b0;
      else if (!sel_b && !b_en_ff && !clk_a)
        a_en_ff <= 1'b1;
      if (!sel_b && !clk_b)
        b_en_ff <= 1'b0;
      else if (sel_b && !a_en_ff && !clk_b)
        b_en_ff <= 1'b1;
    end
  end

  // Enables change only while their clock is low, so no runt pulse
  assign clk_out = (clk_a & a_en_ff) | (clk_b & b_en_ff);
  assign sel_b_done = b_en_ff;
endmodule

//--- rtl/oscc_pkg.sv
// Purpose: Shared constants and types for the oscillator clock source control block.
// Assumes: AXI4-Lite register access with 32-bit data on a 250 MHz aclk.
// Notes: Oscillator behaviour is modelled as enable and ready signalling on aclk.
package oscc_pkg;
  // Register byte offsets
  localparam logic [11:0] OSCC_CTRL_OFS = 12'h000;
  localparam logic [11:0] OSCC_STAT_OFS = 12'h004;
  localparam logic [11:0] OSCC_PCLK_OFS = 12'h008;
  localparam logic [11:0] OSCC_CFG_OFS = 12'h00C;
  // Control register fields
  localparam int OSCC_SCS_LSB = 0;
  localparam int OSCC_IFS_LSB = 3;
  // Status register fields
  localparam int OSCC_HFS_BIT = 0;
  localparam int OSCC_LFR_BIT = 1;
  localparam int OSCC_HFR_BIT = 4;
  localparam int OSCC_FRC_BIT = 8;
  localparam int OSCC_SRC_LSB = 12;
  // Reset values
  localparam logic [3:0] OSCC_IFS_RST = 4'h7;
  localparam logic [1:0] OSCC_SCS_RST = 2'h0;
  // Clock source configuration codes
  localparam logic [1:0] OSCC_CFG_HIGH = 2'h3;
  localparam logic [1:0] OSCC_CFG_MED = 2'h2;
  localparam logic [1:0] OSCC_CFG_LOW = 2'h1;
  localparam logic [1:0] OSCC_CFG_INT = 2'h0;
  // Frequency select codes
  localparam logic [3:0] OSCC_IFS_16M = 4'hF;
  localparam logic [3:0] OSCC_IFS_62K = 4'h4;
  localparam logic [3:0] OSCC_IFS_HF_MIN = 4'h2;
  // AXI responses
  localparam logic [1:0] OSCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] OSCC_RESP_SLVERR = 2'h2;
  // Timing
  localparam int OSCC_CLK_MHZ = 250;
  localparam int OSCC_HF_START_NS = 2000;
  localparam int OSCC_HF_START_CYC = (OSCC_HF_START_NS * OSCC_CLK_MHZ + 999) / 1000;
  localparam int OSCC_HF_STABLE_CYC = 2 * OSCC_HF_START_CYC;
  localparam int OSCC_LF_START_CYC = 2;
  localparam int OSCC_EXT_SW_CYC = 2;

  typedef enum logic [1:0] {OSCC_SRC_EXT, OSCC_SRC_HF, OSCC_SRC_LF} oscc_src_t;

  // Per-peripheral clock request bundle from the device
  typedef struct packed {
    logic [1:0] conv_sel;
    logic [1:0] wave_sel;
    logic [1:0] nco_sel;
    logic [1:0] pwm_sel;
    logic [1:0] t1_sel;
    logic [2:0] clc_sel;
  } oscc_pclk_t;

  // Oscillator enable bundle
  typedef struct packed {
    logic hf_en;
    logic lf_en;
    logic frc_en;
  } oscc_osc_en_t;
endpackage

//--- rtl/oscc_top.sv
// Purpose: Oscillator and clock source control with AXI4-Lite registers.
// Assumes: Oscillators are modelled as enable/running levels sampled on aclk.
// Notes: Postscaled clocks are produced by a divider clocked on hf_osc_clk.
// Notes on behaviour
// - Power-up clock source type comes from two-bit configuration field.
// - Config 11 high, 10 medium, 01 low power external, 00 internal.
// - External modes use logic-level pin clock directly as system clock.
// - Internal mode frees clock input pin for general I/O.
// - Clock output pin is I/O or clock output per configuration bit.
// - Clock-out enable is active low; zero drives clock on the pin.
// - High oscillator nominal 16 MHz feeds postscaler chosen by select.
// - Select 1111 is 16 MHz halving to 0100, 001x 31.25k, 000x LF.
// - High oscillator on for HF select and internal config or select 1x.
// - Start-up oscillator clocks circuits until high oscillator is up.
// - High ready flag follows high oscillator running.
// - High stable flag only once oscillator settles within 0.5 percent.
// - Low oscillator nominal 31 kHz reaches mux without postscaler.
// - Low oscillator on for 31 kHz select and select 1x.
// - Low oscillator also runs when power-up or watchdog timer enabled.
// - Low ready flag follows low oscillator running.
// - Peripheral oscillator starts automatically on any peripheral request; here only frc_request and conv_sel[0] with pclk_sel_ff[0] start it.
// - Peripheral oscillator keeps running during sleep.
// - Each peripheral may only pick its documented clock choices.
// - Software switches system clock between default and internal block.
// - System select 00 config, 1x internal, 01 reserved, reset clears.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
module oscc_top
  import oscc_pkg::*;
#(
  parameter int HF_START_CYC = OSCC_HF_START_CYC,
  parameter int HF_STABLE_CYC = OSCC_HF_STABLE_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] clock_source_cfg,
  input wire logic clock_out_enable_n,
  input wire logic power_up_timer_en,
  input wire logic watchdog_timer_en,
  input wire logic sleep_mode,
  input wire logic frc_request,
  input wire logic oscillator_input_pin,
  input wire logic hf_osc_clk,
  input wire logic lf_osc_clk,
  input wire logic frc_osc_clk,
  input wire logic startup_osc_clk,
  input wire oscc_pclk_t pclk_req,
  output oscc_osc_en_t osc_en,
  output logic sys_clk,
  output logic clock_input_pin_is_io,
  output logic clock_output_pin_oe,
  output logic clock_output_pin_o,
  output logic [6:0] pclk_out,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Counts must fit the 16-bit start-up counter
  if (HF_START_CYC < 1 || HF_STABLE_CYC < HF_START_CYC || HF_STABLE_CYC > 65535)
  begin : g_bad_counts
    $error("oscc_top: start-up counts out of range");
  end

  logic [3:0] freq_sel_ff;
  logic [1:0] sys_sel_ff;
  logic [1:0] cfg_ff;
  logic [1:0] cfg_sync1_ff;
  logic [1:0] cfg_sync2_ff;
  logic [1:0] pin_sync_ff;
  logic [15:0] hf_cnt_ff;
  logic hf_ready_ff;
  logic hf_stable_ff;
  logic [1:0] lf_cnt_ff;
  logic lf_ready_ff;
  logic [8:0] div_ff;
  logic [8:0] pclk_sel_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic use_internal;
  logic hf_setting;
  logic lf_setting;
  logic int_clk;
  logic post_clk;
  logic hf_side_clk;
  logic [1:0] ext_sync_ff;

  // Strap capture on the third edge after release; pin passes two flops first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_sync1_ff <= 2'h0;
      cfg_sync2_ff <= 2'h0;
    end
    else
    begin
      cfg_sync1_ff <= clock_source_cfg;
      cfg_sync2_ff <= cfg_sync1_ff;
    end
  end

  // Latch power-up source type; later strap motion is ignored
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_ff <= OSCC_CFG_INT;
    else if (pin_sync_ff == 2'h2) // Second stage holds the strap only from here
      cfg_ff <= cfg_sync2_ff;
  end

  // Capture sequencing counter for the strap latch, stopping at 3
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_sync_ff <= 2'h0;
    else if (pin_sync_ff != 2'h3)
      pin_sync_ff <= pin_sync_ff + 2'h1;
  end

  // Internal block chosen by strap 00 or run-time select 1x
  assign use_internal = (cfg_ff == OSCC_CFG_INT) || sys_sel_ff[1];
  // Select 0100 and above, plus 001x, are derived from the high oscillator
  assign hf_setting = (freq_sel_ff[3:1] != 3'h0);
  assign lf_setting = (freq_sel_ff[3:1] == 3'h0);

  // Oscillator enables
  always_comb
  begin
    osc_en.hf_en = hf_setting && use_internal;
    osc_en.lf_en = (lf_setting && sys_sel_ff[1]) || (lf_setting && use_internal)
      || power_up_timer_en || watchdog_timer_en;
    osc_en.frc_en = frc_request || (pclk_sel_ff[0] && pclk_req.conv_sel[0]);
  end

  // High oscillator ready after start-up, stable after settling
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !osc_en.hf_en)
    begin
      hf_cnt_ff <= 16'h0000;
      hf_ready_ff <= 1'b0;
      hf_stable_ff <= 1'b0;
    end
    else
    begin
      if (hf_cnt_ff != 16'(HF_STABLE_CYC))
        hf_cnt_ff <= hf_cnt_ff + 16'h0001;
      hf_ready_ff <= (hf_cnt_ff >= 16'(HF_START_CYC));
      hf_stable_ff <= (hf_cnt_ff == 16'(HF_STABLE_CYC));
    end
  end

  // Low oscillator ready after a short start-up
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !osc_en.lf_en)
    begin
      lf_cnt_ff <= 2'h0;
      lf_ready_ff <= 1'b0;
    end
    else
    begin
      if (lf_cnt_ff != 2'(OSCC_LF_START_CYC))
        lf_cnt_ff <= lf_cnt_ff + 2'h1;
      lf_ready_ff <= (lf_cnt_ff == 2'(OSCC_LF_START_CYC));
    end
  end

  // Postscaler: a binary counter clocked by the high oscillator
  always_ff @(posedge hf_osc_clk or negedge aresetn)
  begin
    if (!aresetn)
      div_ff <= 9'h000;
    else
      div_ff <= div_ff + 9'h001;
  end

  // Tap choice: div_ff[k] runs at the high rate over 2^(k+1)
  always_comb
  begin
    if (freq_sel_ff == OSCC_IFS_16M)
      post_clk = hf_osc_clk;
    else if (freq_sel_ff[3])
      post_clk = div_ff[4'hE - freq_sel_ff]; // 8 MHz down to 125 kHz
    else if (freq_sel_ff[2])
      post_clk = div_ff[4'hB - freq_sel_ff]; // 500 kHz down to 62.5 kHz
    else
      post_clk = div_ff[8]; // 001x at 31.25 kHz; 000x takes the low oscillator
  end

  // Start-up oscillator stands in until the high oscillator is stable
  oscc_glitch_mux u_hf_mux
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_a(startup_osc_clk),
    .clk_b(post_clk),
    .sel_b(hf_stable_ff),
    .clk_out(hf_side_clk),
    .sel_b_done()
  );

  // Low oscillator goes straight to the mux, no postscaler
  oscc_glitch_mux u_int_mux
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_a(hf_side_clk),
    .clk_b(lf_osc_clk),
    .sel_b(lf_setting && lf_ready_ff),
    .clk_out(int_clk),
    .sel_b_done()
  );

  // Pin level taken to aclk for status only; clock path stays direct
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_sync_ff <= 2'h0;
    else
      ext_sync_ff <= {ext_sync_ff[0], oscillator_input_pin};
  end

  // Final source mux, external pin used directly in external modes
  oscc_glitch_mux u_sys_mux
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_a(oscillator_input_pin),
    .clk_b(int_clk),
    .sel_b(use_internal),
    .clk_out(sys_clk),
    .sel_b_done()
  );

  // Pin functions
  assign clock_input_pin_is_io = (cfg_ff == OSCC_CFG_INT);
  assign clock_output_pin_oe = !clock_out_enable_n;
  assign clock_output_pin_o = clock_out_enable_n ? 1'b0 : sys_clk;

  // Peripheral clock choices; illegal selections fall back to system clock
  always_comb
  begin
    pclk_out[0] = pclk_req.conv_sel[0] ? frc_osc_clk : sys_clk;
    pclk_out[1] = pclk_req.wave_sel[0] ? hf_osc_clk : sys_clk;
    pclk_out[2] = pclk_req.nco_sel[0] ? hf_osc_clk : sys_clk;
    pclk_out[3] = pclk_req.pwm_sel[0] ? div_ff[0] : sys_clk;
    pclk_out[4] = pclk_req.t1_sel[0] ? lf_osc_clk : sys_clk;
    case (pclk_req.clc_sel)
      3'h1: pclk_out[5] = frc_osc_clk;
      3'h2: pclk_out[5] = hf_osc_clk;
      3'h3: pclk_out[5] = lf_osc_clk;
      default: pclk_out[5] = sys_clk;
    endcase
    pclk_out[6] = sys_clk; // Timers zero and two run on system clock only
  end

  // Peripheral oscillator request mask from software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pclk_sel_ff <= 9'h001;
    else if (aw_got_ff && w_got_ff && !bvalid_ff && awaddr_ff == OSCC_PCLK_OFS && wstrb_ff[0])
      pclk_sel_ff <= {1'b0, wdata_ff[7:0]};
  end

  // Write channel capture, address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end
    else if (aw_got_ff && w_got_ff && !bvalid_ff)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;

  // Control register write; reserved select code 01 is stored as written
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      freq_sel_ff <= OSCC_IFS_RST;
      sys_sel_ff <= OSCC_SCS_RST;
    end
    else if (aw_got_ff && w_got_ff && !bvalid_ff && awaddr_ff == OSCC_CTRL_OFS && wstrb_ff[0])
    begin
      freq_sel_ff <= wdata_ff[OSCC_IFS_LSB +: 4];
      sys_sel_ff <= wdata_ff[OSCC_SCS_LSB +: 2];
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= OSCC_RESP_OKAY;
    end
    else if (aw_got_ff && w_got_ff && !bvalid_ff)
    begin
      bvalid_ff <= 1'b1;
      if (awaddr_ff == OSCC_CTRL_OFS || awaddr_ff == OSCC_PCLK_OFS)
        bresp_ff <= OSCC_RESP_OKAY;
      else
        bresp_ff <= OSCC_RESP_SLVERR; // Status and strap words are read-only
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;

  // Read path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= OSCC_RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= OSCC_RESP_OKAY;
      rdata_ff <= 32'h00000000;
      if (s_axi_araddr == OSCC_CTRL_OFS)
        rdata_ff <= {25'h0, freq_sel_ff, 1'b0, sys_sel_ff};
      else if (s_axi_araddr == OSCC_STAT_OFS)
        rdata_ff <= {19'h0, use_internal, 3'h0, osc_en.frc_en, 3'h0, hf_ready_ff,
                     2'h0, lf_ready_ff, hf_stable_ff};
      else if (s_axi_araddr == OSCC_PCLK_OFS)
        rdata_ff <= {23'h0, pclk_sel_ff};
      else if (s_axi_araddr == OSCC_CFG_OFS)
        rdata_ff <= {27'h0, ext_sync_ff[1], clock_out_enable_n, sleep_mode, cfg_ff};
      else
        rresp_ff <= OSCC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule
